/* rtl/sspc_pkg.sv */
// shared constants for the sensor serial port configuration block
package sspc_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  // baud codes and divisors (clocks per bit)
  localparam logic [2:0] BAUD_9600 = 3'h0;
  localparam logic [2:0] BAUD_19200 = 3'h1;
  localparam logic [2:0] BAUD_38400 = 3'h2;
  localparam logic [2:0] BAUD_57600 = 3'h3;
  localparam logic [2:0] BAUD_115200 = 3'h4;
  localparam logic [15:0] DIV_9600 = 16'(CLK_HZ / 9600);
  localparam logic [15:0] DIV_19200 = 16'(CLK_HZ / 19200);
  localparam logic [15:0] DIV_38400 = 16'(CLK_HZ / 38400);
  localparam logic [15:0] DIV_57600 = 16'(CLK_HZ / 57600);
  localparam logic [15:0] DIV_115200 = 16'(CLK_HZ / 115200);
  // activation modes
  localparam logic [1:0] ACT_CONT = 2'h0;
  localparam logic [1:0] ACT_POLL = 2'h1;
  localparam logic [1:0] ACT_LEADER = 2'h2;
  localparam logic [1:0] ACT_FOLLOWER = 2'h3;
  // register byte offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_ADDR = 4'h4;
  localparam logic [3:0] OFS_STAT = 4'h8;
  localparam logic [3:0] OFS_DATA = 4'hc;
  // ctrl fields
  localparam int CTRL_BAUD_LSB = 0;
  localparam int CTRL_ACT_LSB = 4;
  localparam int CTRL_DIFF_BIT = 8;
  localparam int CTRL_PAR_BIT = 9;
  localparam int CTRL_DEFAULT_BIT = 12;
  // reset values and address limit
  localparam logic [2:0] RST_BAUD = BAUD_9600;
  localparam logic [7:0] RST_ADDR = 8'h01;
  localparam logic [7:0] ADDR_MAX = 8'hf7;
  localparam logic [1:0] RST_ACT = ACT_CONT;
  // bit slot reached after the 8 data bits
  localparam logic [3:0] SLOT_STOP8 = 4'h9;
  localparam logic [3:0] SLOT_STOP9 = 4'ha;
endpackage

/* rtl/sspc_core.sv */
// serial port front end: configuration registers, uart receive/transmit, address filter
//
// Our own choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
module sspc_core (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic rxd_in,
  output logic txd_out,
  output logic txd_oe_out,
  output logic diff_mode_out,
  output logic session_drop_out
);
  typedef enum logic [3:0] {
    SSPC_RX_IDLE = 4'h1,
    SSPC_RX_START = 4'h2,
    SSPC_RX_BITS = 4'h4,
    SSPC_RX_DONE = 4'h8
  } sspc_rx_t;
  typedef enum logic [2:0] {
    SSPC_TX_IDLE = 3'h1,
    SSPC_TX_SHIFT = 3'h2,
    SSPC_TX_END = 3'h4
  } sspc_tx_t;

  logic [2:0] baud_q;
  logic [1:0] act_q;
  logic diff_var_q;
  logic even_q;
  logic [7:0] addr_q;
  logic ack_q;
  logic [15:0] div;
  logic sync_mode;
  sspc_rx_t rx_state_q;
  logic [15:0] rx_cnt_q;
  logic [3:0] rx_slot_q;
  logic [8:0] rx_sh_q;
  logic rx_par_err_q;
  logic in_frame_q;
  logic first_q;
  logic accept_q;
  logic [7:0] rx_byte_q;
  logic rx_valid_q;
  logic par_errs_q;
  sspc_tx_t tx_state_q;
  logic [15:0] tx_cnt_q;
  logic [3:0] tx_slot_q;
  logic [10:0] tx_sh_q;
  logic tx_go_q;
  logic [7:0] tx_byte_q;
  logic tx_busy_q;
  logic [15:0] gap_q;
  logic wr_ctrl;
  logic wr_addr;
  logic [2:0] new_baud;
  logic [1:0] new_act;
  logic [7:0] new_addr;

  // one divisor drives both directions, whatever the protocol
  always_comb begin
    case (baud_q)
      sspc_pkg::BAUD_19200: div = sspc_pkg::DIV_19200;
      sspc_pkg::BAUD_38400: div = sspc_pkg::DIV_38400;
      sspc_pkg::BAUD_57600: div = sspc_pkg::DIV_57600;
      sspc_pkg::BAUD_115200: div = sspc_pkg::DIV_115200;
      default: div = sspc_pkg::DIV_9600;
    endcase
  end

  assign sync_mode = act_q[1];
  assign wr_ctrl = avs_write_in && !ack_q && avs_address_in == sspc_pkg::OFS_CTRL;
  assign wr_addr = avs_write_in && !ack_q && avs_address_in == sspc_pkg::OFS_ADDR;
  assign new_baud = avs_writedata_in[sspc_pkg::CTRL_BAUD_LSB +: 3];
  assign new_act = avs_writedata_in[sspc_pkg::CTRL_ACT_LSB +: 2];
  assign new_addr = avs_writedata_in[7:0];

  // bus handshake: every access answers one cycle after it is seen
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ack_q <= 1'b0;
    end else if (ce_in) begin
      ack_q <= (avs_read_in || avs_write_in) && !ack_q;
    end
  end

  // configuration registers
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      baud_q <= sspc_pkg::RST_BAUD;
      act_q <= sspc_pkg::RST_ACT;
      diff_var_q <= 1'b0;
      addr_q <= sspc_pkg::RST_ADDR;
    end else if (ce_in) begin
      if (wr_ctrl) begin
        if (avs_writedata_in[sspc_pkg::CTRL_DEFAULT_BIT]) begin
          // factory default resets the activation mode and lowers 115200 to 57600; other settings kept
          act_q <= sspc_pkg::RST_ACT;
          if (baud_q == sspc_pkg::BAUD_115200) begin
            baud_q <= sspc_pkg::BAUD_57600;
          end
        end else begin
          act_q <= new_act;
          diff_var_q <= avs_writedata_in[sspc_pkg::CTRL_DIFF_BIT];
          // top rate is refused unless polled; keep old rate then, but drop an old top rate to 57600
          if (new_baud <= sspc_pkg::BAUD_115200 &&
              (new_baud != sspc_pkg::BAUD_115200 || new_act == sspc_pkg::ACT_POLL)) begin
            baud_q <= new_baud;
          end else if (baud_q == sspc_pkg::BAUD_115200 && new_act != sspc_pkg::ACT_POLL) begin
            baud_q <= sspc_pkg::BAUD_57600;
          end
        end
      end
      if (wr_addr && new_addr >= 8'h01 && new_addr <= sspc_pkg::ADDR_MAX) begin
        addr_q <= new_addr;
      end
    end
  end

  // parity: starts none, flips to even on first bad frame, kept by defaults
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      even_q <= 1'b0;
    end else if (ce_in) begin
      // a detected parity frame beats a software clear in the same cycle
      if (rx_par_err_q) begin
        even_q <= 1'b1;
      end else if (wr_ctrl && !avs_writedata_in[sspc_pkg::CTRL_DEFAULT_BIT] &&
                   !avs_writedata_in[sspc_pkg::CTRL_PAR_BIT]) begin
        even_q <= 1'b0;
      end
    end
  end

  // receiver: 9th slot is parity or stop depending on even_q
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rx_state_q <= SSPC_RX_IDLE;
      rx_cnt_q <= 16'h0000;
      rx_slot_q <= 4'h0;
      rx_sh_q <= 9'h000;
      rx_par_err_q <= 1'b0;
    end else if (ce_in) begin
      rx_par_err_q <= 1'b0;
      case (rx_state_q)
        SSPC_RX_IDLE: begin
          if (!rxd_in) begin
            rx_state_q <= SSPC_RX_START;
            rx_cnt_q <= {1'b0, div[15:1]};
          end
        end
        SSPC_RX_START: begin
          if (rx_cnt_q != 16'h0000) begin
            rx_cnt_q <= rx_cnt_q - 16'h0001;
          end else if (rxd_in) begin
            rx_state_q <= SSPC_RX_IDLE; // glitch, not a start bit
          end else begin
            rx_state_q <= SSPC_RX_BITS;
            rx_cnt_q <= div - 16'h0001; // one bit is div clocks, end edge included
            rx_slot_q <= 4'h1;
          end
        end
        SSPC_RX_BITS: begin
          if (rx_cnt_q != 16'h0000) begin
            rx_cnt_q <= rx_cnt_q - 16'h0001;
          end else begin
            rx_cnt_q <= div - 16'h0001;
            rx_slot_q <= rx_slot_q + 4'h1;
            if (rx_slot_q == (even_q ? sspc_pkg::SLOT_STOP9 : sspc_pkg::SLOT_STOP8)) begin
              rx_state_q <= SSPC_RX_DONE;
              // with no parity, a 0 in the stop slot marks a parity-bearing frame
              rx_par_err_q <= even_q ? (^rx_sh_q) : !rxd_in;
            end else begin
              rx_sh_q <= {rxd_in, rx_sh_q[8:1]};
            end
          end
        end
        SSPC_RX_DONE: begin
          if (rxd_in) begin
            rx_state_q <= SSPC_RX_IDLE;
          end
        end
        default: rx_state_q <= SSPC_RX_IDLE;
      endcase
    end
  end

  // frame tracking: an 8.5-bit-time silence ends a frame; first byte is the address
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      gap_q <= 16'h0000;
      in_frame_q <= 1'b0;
      first_q <= 1'b1;
      accept_q <= 1'b0;
      rx_byte_q <= 8'h00;
      rx_valid_q <= 1'b0;
      par_errs_q <= 1'b0;
      session_drop_out <= 1'b0;
    end else if (ce_in) begin
      session_drop_out <= 1'b0;
      // reads clear first, so a new byte or error in the same cycle wins
      if (avs_read_in && ack_q && avs_address_in == sspc_pkg::OFS_DATA) begin
        rx_valid_q <= 1'b0;
      end
      if (avs_read_in && ack_q && avs_address_in == sspc_pkg::OFS_STAT) begin
        par_errs_q <= 1'b0;
      end
      if (rx_state_q != SSPC_RX_IDLE) begin
        gap_q <= 16'h0000;
      end else if (gap_q != 16'hffff) begin
        gap_q <= gap_q + 16'h0001;
      end
      if (wr_ctrl || wr_addr) begin
        // link settings changed: forget the half-seen frame
        in_frame_q <= 1'b0;
        first_q <= 1'b1;
        accept_q <= 1'b0;
        session_drop_out <= 1'b1;
      end else if (rx_state_q == SSPC_RX_BITS && rx_cnt_q == 16'h0000 &&
                   rx_slot_q == (even_q ? sspc_pkg::SLOT_STOP9 : sspc_pkg::SLOT_STOP8)) begin
        // the parity flag lags one cycle, so judge the bits directly here
        if (even_q ? (^rx_sh_q) : !rxd_in) begin
          par_errs_q <= 1'b1;
          accept_q <= 1'b0; // the switching packet is lost
        end else if (first_q) begin
          // sync followers share addresses; the filter still applies
          accept_q <= (even_q ? rx_sh_q[7:0] : rx_sh_q[8:1]) == addr_q &&
                      act_q != sspc_pkg::ACT_LEADER;
        end
        first_q <= 1'b0;
        in_frame_q <= 1'b1;
        rx_byte_q <= even_q ? rx_sh_q[7:0] : rx_sh_q[8:1];
        rx_valid_q <= !first_q && accept_q;
      end else if (gap_q == {div[12:0], 3'h0} + {2'h0, div[14:1]}) begin
        in_frame_q <= 1'b0;
        first_q <= 1'b1;
      end
    end
  end

  // transmit request from software, only in continuous or polled mode
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_go_q <= 1'b0;
      tx_byte_q <= 8'h00;
    end else if (ce_in) begin
      if (avs_write_in && !ack_q && avs_address_in == sspc_pkg::OFS_DATA && !tx_busy_q &&
          act_q[1] == 1'b0) begin
        tx_go_q <= 1'b1;
        tx_byte_q <= avs_writedata_in[7:0];
      end else begin
        tx_go_q <= 1'b0;
      end
    end
  end

  // transmitter: start, 8 data, optional even parity, stop
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_state_q <= SSPC_TX_IDLE;
      tx_cnt_q <= 16'h0000;
      tx_slot_q <= 4'h0;
      tx_sh_q <= 11'h7ff;
      tx_busy_q <= 1'b0;
      txd_out <= 1'b1;
      txd_oe_out <= 1'b0;
    end else if (ce_in) begin
      case (tx_state_q)
        SSPC_TX_IDLE: begin
          txd_out <= 1'b1;
          txd_oe_out <= !(diff_var_q || sync_mode); // point-to-point drives idle line
          if (tx_go_q) begin
            tx_state_q <= SSPC_TX_SHIFT;
            tx_busy_q <= 1'b1;
            tx_sh_q <= even_q ? {1'b1, ^tx_byte_q, tx_byte_q, 1'b0} : {2'h3, tx_byte_q, 1'b0};
            tx_slot_q <= even_q ? 4'hb : 4'ha;
            tx_cnt_q <= 16'h0000;
          end
        end
        SSPC_TX_SHIFT: begin
          txd_oe_out <= 1'b1;
          if (tx_cnt_q != 16'h0000) begin
            tx_cnt_q <= tx_cnt_q - 16'h0001;
          end else if (tx_slot_q == 4'h0) begin
            tx_state_q <= SSPC_TX_END;
          end else begin
            txd_out <= tx_sh_q[0];
            tx_sh_q <= {1'b1, tx_sh_q[10:1]};
            tx_slot_q <= tx_slot_q - 4'h1;
            tx_cnt_q <= div - 16'h0001;
          end
        end
        SSPC_TX_END: begin
          tx_busy_q <= 1'b0;
          tx_state_q <= SSPC_TX_IDLE;
        end
        default: tx_state_q <= SSPC_TX_IDLE;
      endcase
    end
  end

  // differential wiring forced while any sync role is set
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      diff_mode_out <= 1'b0;
    end else if (ce_in) begin
      diff_mode_out <= diff_var_q || sync_mode;
    end
  end

  // read mux and waitrequest
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      avs_readdata_out <= 32'h00000000;
      avs_waitrequest_out <= 1'b1;
    end else if (ce_in) begin
      avs_waitrequest_out <= !((avs_read_in || avs_write_in) && !ack_q);
      case (avs_address_in)
        sspc_pkg::OFS_CTRL: avs_readdata_out <= {22'h0, even_q, diff_var_q, 2'h0, act_q, 1'b0, baud_q};
        sspc_pkg::OFS_ADDR: avs_readdata_out <= {24'h0, addr_q};
        sspc_pkg::OFS_STAT: avs_readdata_out <= {26'h0, in_frame_q, par_errs_q, tx_busy_q,
                                                 rx_valid_q, diff_mode_out, even_q};
        sspc_pkg::OFS_DATA: avs_readdata_out <= {24'h0, rx_byte_q};
        default: avs_readdata_out <= 32'h00000000;
      endcase
    end
  end
endmodule

/* bench/sspc_props.sv */
// port-level assertions for the serial port configuration block
`timescale 1ns/1ps
module sspc_props (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic rxd_in,
  input wire logic txd_out,
  input wire logic txd_oe_out,
  input wire logic diff_mode_out,
  input wire logic session_drop_out
);
  // one clock domain, so clocking and disable are shared
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  // register access: answer one edge after the request, one cycle long
  property p_ack; (avs_read_in || avs_write_in) && avs_waitrequest_out && ce_in |=> !avs_waitrequest_out; endproperty
  a_ack: assert property (p_ack) else $error("access not answered in time");
  property p_one; !avs_waitrequest_out |=> avs_waitrequest_out; endproperty
  a_one: assert property (p_one) else $error("answer longer than one cycle");
  property p_idle; !avs_read_in && !avs_write_in && avs_waitrequest_out |=> avs_waitrequest_out; endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  property p_unmap; avs_read_in && !avs_waitrequest_out && avs_address_in[1:0] != 2'h0 |-> avs_readdata_out == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  // session drop only follows a write and lasts one cycle
  property p_drop; session_drop_out |-> $past(avs_write_in) || $past(avs_write_in, 2); endproperty
  a_drop: assert property (p_drop) else $error("session drop without write");
  property p_drop1; session_drop_out |=> !session_drop_out; endproperty
  a_drop1: assert property (p_drop1) else $error("session drop too long");
  // line rests at mark when released; a start bit is always driven
  property p_mark; !txd_oe_out |-> txd_out; endproperty
  a_mark: assert property (p_mark) else $error("line not at mark while released");
  property p_start; $fell(txd_out) |-> txd_oe_out; endproperty
  a_start: assert property (p_start) else $error("start bit not driven");
  property p_rst; $rose(resetn_in) |-> avs_waitrequest_out && !session_drop_out; endproperty
  a_rst: assert property (p_rst) else $error("bad state at reset release");
endmodule

bind sspc_core sspc_props sspc_chk_u (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
  .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .rxd_in(rxd_in), .txd_out(txd_out), .txd_oe_out(txd_oe_out),
  .diff_mode_out(diff_mode_out), .session_drop_out(session_drop_out));

/* bench/sspc_host_model.sv */
// host-side serial model: sends and receives characters on the data wires
`timescale 1ns/1ps
module sspc_host_model #(
  parameter int DIV = 434
) (
  input wire logic clk_in,
  input wire logic line_in,
  output logic line_out
);
  // idle at mark, as the pulled-up wire rests; sole master on the wire
  initial line_out = 1'b1;

  // one character, lsb first, optional even parity; host uses the device baud
  task automatic send(input logic [7:0] b, input logic par);
    for (int i = 0; i < (par ? 11 : 10); i++) begin
      @(posedge clk_in);
      line_out <= (i == 0) ? 1'b0 : (i < 9) ? b[i-1] : (par && i == 9) ? ^b : 1'b1;
      repeat (DIV - 1) @(posedge clk_in);
    end
  endtask

  // samples mid-bit; p is the bit after the data (parity or stop)
  task automatic recv(output logic [7:0] b, output logic p, output logic ok);
    int n;
    n = 0;
    b = 8'h00;
    while (line_in !== 1'b0 && n < 40 * DIV) begin
      @(posedge clk_in);
      n++;
    end
    ok = (n < 40 * DIV);
    repeat (DIV + DIV / 2) @(posedge clk_in);
    for (int i = 0; i < 8; i++) begin
      b[i] = line_in;
      repeat (DIV) @(posedge clk_in);
    end
    p = line_in;
  endtask
endmodule

/* bench/tb.sv */
// self-checking bench for the serial port configuration block
`timescale 1ns/1ps
module tb;
  localparam int DIV = sspc_pkg::DIV_115200;
  logic clk_in;
  logic resetn_in;
  logic [3:0] avs_address_in;
  logic avs_read_in, avs_write_in, avs_waitrequest_out;
  logic [31:0] avs_writedata_in, avs_readdata_out, q;
  logic rxd_in, txd_out, txd_oe_out, diff_mode_out, session_drop_out, host_line, ok, rp, ce_in;
  logic [7:0] rb;
  int err_count, n_checks;

  // one node on the wire, inside the 32-node segment limit
  sspc_core dut_u (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out), .rxd_in(rxd_in),
    .txd_out(txd_out), .txd_oe_out(txd_oe_out), .diff_mode_out(diff_mode_out),
    .session_drop_out(session_drop_out));
  // pull-up when the device releases the wire
  assign host_line = txd_oe_out ? txd_out : 1'b1;
  sspc_host_model #(.DIV(DIV)) host_u (.clk_in(clk_in), .line_in(host_line), .line_out(rxd_in));

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  task test_done;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one bus access, held until waitrequest is sampled low
  task xfer(logic wr, logic [3:0] a, logic [31:0] d);
    int n;
    @(posedge clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 20);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    if (n >= 20) begin
      err_count++;
      test_done();
    end
  endtask

  task rd(string nm, logic [3:0] a, logic [31:0] m, logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(nm, q & m, e);
  endtask

  // frame closes after the idle gap the receiver waits for
  task gap;
    repeat (13 * DIV) @(posedge clk_in);
  endtask

  initial begin
    resetn_in = 1'b0;
    ce_in = 1'b1;
    avs_address_in = 4'h0;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_writedata_in = 32'h0;
    err_count = 0;
    n_checks = 0;
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    rd("ctrl_rst", sspc_pkg::OFS_CTRL, 32'h337, 32'h0);
    rd("addr_rst", sspc_pkg::OFS_ADDR, 32'hff, 32'h1);
    rd("unmapped", 4'h2, 32'hffffffff, 32'h0);
    $display("test reset done");
    // lower rate codes 1 to 3, then the fastest rate gated by activation mode
    for (int c = 1; c < 4; c++) begin
      xfer(1'b1, sspc_pkg::OFS_CTRL, 32'(c));
      rd("baud", sspc_pkg::OFS_CTRL, 32'h337, 32'(c));
    end
    xfer(1'b1, sspc_pkg::OFS_CTRL, 32'h4);
    rd("fast_refused", sspc_pkg::OFS_CTRL, 32'h337, 32'h3);
    xfer(1'b1, sspc_pkg::OFS_CTRL, 32'h14);
    rd("fast_poll", sspc_pkg::OFS_CTRL, 32'h337, 32'h14);
    xfer(1'b1, sspc_pkg::OFS_CTRL, 32'h24);
    rd("fast_leader", sspc_pkg::OFS_CTRL, 32'h337, 32'h23);
    rd("stat_diff", sspc_pkg::OFS_STAT, 32'h2, 32'h2);
    chk("diff_sync", 32'(diff_mode_out), 32'h1);
    // the wiring level trails the write by one registered stage
    xfer(1'b1, sspc_pkg::OFS_CTRL, 32'h100);
    @(posedge clk_in);
    chk("diff_var", 32'(diff_mode_out), 32'h1);
    xfer(1'b1, sspc_pkg::OFS_CTRL, 32'h0);
    @(posedge clk_in);
    chk("single_var", 32'(diff_mode_out), 32'h0);
    $display("test baud done");
    xfer(1'b1, sspc_pkg::OFS_ADDR, 32'h0);
    rd("addr_zero", sspc_pkg::OFS_ADDR, 32'hff, 32'h1);
    xfer(1'b1, sspc_pkg::OFS_ADDR, 32'hf8);
    rd("addr_high", sspc_pkg::OFS_ADDR, 32'hff, 32'h1);
    xfer(1'b1, sspc_pkg::OFS_ADDR, 32'hf7);
    rd("addr_max", sspc_pkg::OFS_ADDR, 32'hff, 32'hf7);
    // enable low: a held write must wait and land only after release
    ce_in <= 1'b0;
    fork
      xfer(1'b1, sspc_pkg::OFS_ADDR, 32'h22);
      begin
        repeat (5) @(posedge clk_in);
        chk("ce_frozen", 32'(avs_waitrequest_out), 32'h1);
        ce_in <= 1'b1;
      end
    join
    rd("ce_write", sspc_pkg::OFS_ADDR, 32'hff, 32'h22);
    xfer(1'b1, sspc_pkg::OFS_ADDR, 32'h5);
    chk("drop", 32'(session_drop_out), 32'h1);
    xfer(1'b1, sspc_pkg::OFS_CTRL, 32'h13);
    xfer(1'b1, sspc_pkg::OFS_CTRL, 32'h1000);
    rd("dflt_ctrl", sspc_pkg::OFS_CTRL, 32'h337, 32'h3);
    rd("dflt_addr", sspc_pkg::OFS_ADDR, 32'hff, 32'h5);
    $display("test address done");
    // serial traffic at the fastest rate, host addresses node 5
    xfer(1'b1, sspc_pkg::OFS_CTRL, 32'h14);
    host_u.send(8'h05, 1'b0);
    host_u.send(8'ha5, 1'b0);
    gap();
    rd("rx_valid", sspc_pkg::OFS_STAT, 32'h4, 32'h4);
    rd("rx_byte", sspc_pkg::OFS_DATA, 32'hff, 32'ha5);
    host_u.send(8'h06, 1'b0);
    host_u.send(8'h3c, 1'b0);
    gap();
    rd("foreign", sspc_pkg::OFS_STAT, 32'h4, 32'h0);
    host_u.send(8'h05, 1'b1);
    host_u.send(8'h5a, 1'b1);
    gap();
    rd("even_switch", sspc_pkg::OFS_STAT, 32'h15, 32'h11);
    host_u.send(8'h05, 1'b1);
    host_u.send(8'h3c, 1'b1);
    gap();
    rd("even_rx", sspc_pkg::OFS_DATA, 32'hff, 32'h3c);
    $display("test receive done");
    fork
      host_u.recv(rb, rp, ok);
      xfer(1'b1, sspc_pkg::OFS_DATA, 32'h96);
    join
    chk("tx_start", 32'(ok), 32'h1);
    chk("tx_byte", 32'(rb), 32'h96);
    chk("tx_par", 32'(rp), 32'h0);
    xfer(1'b1, sspc_pkg::OFS_CTRL, 32'h1000);
    rd("dflt_par", sspc_pkg::OFS_CTRL, 32'h200, 32'h200);
    $display("test transmit done");
    test_done();
  end
endmodule
